/* File: hw/rdp_display_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "rdp_display_regs.vh"
// Functional notes
// R1: rate-only, total-only or combined operation
// R2: combined mode toggles view on button press
// R3: non-default view reverts after 30 seconds
// R4: default view shown after reset
// R5: non-default view flashes identifier every 8s
// R6: rate point from zero to digits-1
// R7: input-factor, user points or live points scaling
// R8: rate equals frequency times scale over input
// R9: weighted average filter strength 0 to 8
// R10: round rate to step 1..5000
// R11: low warning when rate below limit
// R12: high warning when rate above limit
// R13: flash mode blinks value once per second
// R14: dash mode flashes dashes once per second
// R15: over/under or high/low letters per side
// R16: warning ends once rate inside limits
// R17: slow range holds rate until timeout
// R18: fast range up to 100 kHz gated count
// R19: period average over configured seconds
// R20: rolling mean of last N period results
// R21: average zeroed on display off or on leaving the averaging ranges
// R22: averaged rate updates only at period end
// R23: warnings compare the displayed rate value
module rdp_display_core #(
    parameter DIGITS = 6,
    parameter MAXCNT = 30,
    parameter CLK_PER_SEC = `RDP_CLOCK_HZ
)(
    input wire clock,
    input wire rst_n,
    input wire pulseIn,
    input wire toggleBtn,
    input wire [3:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [31:0] regRdData,
    input wire [31:0] totalValue,
    output reg [31:0] dispValue,
    output reg [2:0] dispPoint,
    output reg [2:0] dispMessage,
    output reg showingTotal
);
    // ********
    // timing constants
    // ********
    localparam TICK_PER_S = 10; // decisecond tick rate
    localparam [31:0] FAST_MHZ = 1000 * TICK_PER_S / `RDP_HIF_GATE_TICKS; // mHz per pulse in one gate
    localparam [2:0] DP_MAX = DIGITS - 1; // most decimal places
    localparam [5:0] CNT_MAX = MAXCNT; // longest rolling window
    localparam [31:0] TICK_DIV = CLK_PER_SEC / TICK_PER_S;
    localparam [15:0] REVERT_T = `RDP_REVERT_S * TICK_PER_S;
    localparam [15:0] ALTID_T = `RDP_ALTID_S * TICK_PER_S;
    localparam [31:0] FAST_GATE = TICK_DIV * `RDP_HIF_GATE_TICKS; // clocks per fast gate

    // ********
    // registers
    // ********
    reg [15:0] modeReg; // packed mode fields
    reg [31:0] inFactor; // rate input factor
    reg [31:0] scaleFactor; // rate scale factor
    reg [3:0] filterStrength; // 0..8
    reg [15:0] roundStep; // 1..5000
    reg [31:0] lowLimit; // low warning limit
    reg [31:0] highLimit; // high warning limit
    reg [15:0] avgSeconds; // averaging period
    reg [5:0] avgCount; // rolling count N
    reg [15:0] timeoutSec; // slow range timeout
    reg [31:0] calFreq1, calFreq2, calScale1, calScale2; // two-point scaling
    reg [1:0] calSel; // cal word select
    wire [1:0] opMode = modeReg[`RDP_MODE_OP_LSB +: 2];
    wire defTotal = modeReg[`RDP_MODE_DEF_BIT];
    wire [2:0] ratePoint = modeReg[`RDP_MODE_DP_LSB +: 3];
    wire [1:0] scaleMethod = modeReg[`RDP_MODE_SM_LSB +: 2];
    wire [2:0] warnStyle = modeReg[`RDP_MODE_WS_LSB +: 3];
    wire [1:0] rangeSel = modeReg[`RDP_MODE_RNG_LSB +: 2];
    wire lowEn = modeReg[`RDP_MODE_LOEN_BIT];
    wire highEn = modeReg[`RDP_MODE_HIEN_BIT];
    wire dispOff = modeReg[`RDP_MODE_DISPOFF_BIT];
    wire isAvg = (rangeSel == `RDP_RNG_AVG) || (rangeSel == `RDP_RNG_ROLL);

    // ********
    // input synchronisers and edge detection
    // ********
    reg [1:0] pulseSync, btnSync; // two-stage synchronisers
    reg pulseLast, btnLast;
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            {pulseSync, btnSync} <= 4'h0;
            {pulseLast, btnLast} <= 2'h0;
        end
        else
        begin
            pulseSync <= {pulseSync[0], pulseIn};
            btnSync <= {btnSync[0], toggleBtn};
            pulseLast <= pulseSync[1];
            btnLast <= btnSync[1];
        end
    end
    wire pulseEdge = pulseSync[1] & ~pulseLast;
    wire btnEdge = btnSync[1] & ~btnLast;

    // ********
    // tick divider: deciseconds, seconds, blink phase
    // ********
    reg [31:0] divCnt;
    reg [3:0] decCnt;
    reg blinkOn; // toggles each half second
    wire tick = (divCnt == TICK_DIV - 32'h1);
    wire secTick = tick && (decCnt == 4'h9);
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            divCnt <= 32'h0;
            decCnt <= 4'h0;
            blinkOn <= 1'b1;
        end
        else if (tick)
        begin
            divCnt <= 32'h0;
            decCnt <= (decCnt == 4'h9) ? 4'h0 : decCnt + 4'h1;
            if (decCnt == 4'h4 || decCnt == 4'h9)
                blinkOn <= ~blinkOn; // one on/off cycle per second
        end
        else
            divCnt <= divCnt + 32'h1;
    end

    // ********
    // register write port
    // ********
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            modeReg <= `RDP_RST_MODE;
            inFactor <= `RDP_RST_FACTOR;
            scaleFactor <= `RDP_RST_FACTOR;
            filterStrength <= 4'h0;
            roundStep <= `RDP_RST_ROUND;
            {lowLimit, highLimit} <= 64'h0;
            avgSeconds <= `RDP_RST_AVGSEC;
            avgCount <= `RDP_RST_AVGCNT;
            timeoutSec <= `RDP_RST_TIMEOUT;
            {calFreq1, calScale1} <= 64'h0;
            {calFreq2, calScale2} <= {32'h1, 32'h1};
            calSel <= 2'h0;
        end
        else if (regWrite)
        begin
            case (regAddr)
                `RDP_ADDR_MODE:
                begin
                    modeReg <= regWrData[15:0];
                    if (regWrData[`RDP_MODE_DP_LSB +: 3] > DP_MAX) // R6
                        modeReg[`RDP_MODE_DP_LSB +: 3] <= DP_MAX; // R6
                end
                `RDP_ADDR_INFACT: inFactor <= (regWrData == 32'h0) ? 32'h1 : regWrData;
                `RDP_ADDR_SCALE: scaleFactor <= regWrData;
                `RDP_ADDR_FILT: filterStrength <= (regWrData[3:0] > 4'h8) ? 4'h8 : regWrData[3:0]; // R9
                `RDP_ADDR_ROUND: roundStep <= (regWrData[15:0] == 16'h0) ? 16'h1
                    : (regWrData[15:0] > 16'h1388) ? 16'h1388 : regWrData[15:0]; // R10
                `RDP_ADDR_LOLIM: lowLimit <= regWrData;
                `RDP_ADDR_HILIM: highLimit <= regWrData;
                `RDP_ADDR_AVG:
                begin
                    avgSeconds <= (regWrData[15:0] == 16'h0) ? 16'h1 : regWrData[15:0];
                    avgCount <= (regWrData[21:16] > CNT_MAX) ? CNT_MAX : regWrData[21:16];
                end
                `RDP_ADDR_TIMEOUT: timeoutSec <= regWrData[15:0];
                `RDP_ADDR_CAL:
                begin
                    // word high bits select which calibration word gets low 30 bits
                    case (regWrData[31:30])
                        2'h0: calFreq1 <= {2'h0, regWrData[29:0]};
                        2'h1: calScale1 <= {2'h0, regWrData[29:0]};
                        2'h2: calFreq2 <= {2'h0, regWrData[29:0]};
                        default: calScale2 <= {2'h0, regWrData[29:0]};
                    endcase
                    calSel <= regWrData[31:30];
                end
                default: ;
            endcase
        end
    end

    // ********
    // frequency measurement in millihertz
    // ********
    reg [31:0] gateCnt; // fast range gate timer
    reg [31:0] fastPulses;
    reg [31:0] periodCnt; // slow range clocks since last pulse
    reg [31:0] freqMilli; // measured frequency, mHz
    reg freqValid; // new sample strobe
    reg [15:0] idleSec; // slow range idle seconds
    reg seenPulse;
    wire [63:0] slowQuot = (CLK_PER_SEC * 64'd1000) / periodCnt; // only read when periodCnt is non-zero
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            {gateCnt, fastPulses, periodCnt, freqMilli} <= 128'h0;
            freqValid <= 1'b0;
            idleSec <= 16'h0;
            seenPulse <= 1'b0;
        end
        else
        begin
            freqValid <= 1'b0;
            if (rangeSel == `RDP_RNG_LOF)
            begin
                // period measurement; hold last value until timeout
                periodCnt <= periodCnt + {31'h0, ~&periodCnt};
                if (pulseEdge)
                begin
                    idleSec <= 16'h0;
                    periodCnt <= 32'h1; // the edge cycle belongs to the new period
                    seenPulse <= 1'b1;
                    if (seenPulse && periodCnt != 32'h0)
                    begin
                        freqMilli <= slowQuot[31:0]; // R17
                        freqValid <= 1'b1;
                    end
                end
                else if (secTick)
                begin
                    idleSec <= idleSec + 16'h1;
                    if (idleSec + 16'h1 >= timeoutSec) // R17
                    begin
                        freqMilli <= 32'h0;
                        freqValid <= 1'b1;
                        seenPulse <= 1'b0;
                    end
                end
            end
            else if (gateCnt == FAST_GATE - 32'h1)
            begin
                // gated count, fine for sustained inputs up to 100 kHz
                gateCnt <= 32'h0;
                fastPulses <= {31'h0, pulseEdge};
                freqMilli <= fastPulses * FAST_MHZ; // R18
                freqValid <= 1'b1;
            end
            else
            begin
                gateCnt <= gateCnt + 32'h1;
                fastPulses <= fastPulses + {31'h0, pulseEdge};
            end
        end
    end

    // ********
    // scaling: freq times scale over input, or two-point
    // ********
    wire [63:0] directWide = ({32'h0, freqMilli} * scaleFactor) / inFactor / 32'd1000; // full-width quotient
    reg [31:0] scaledRate;
    reg signed [63:0] lineTmp;
    always @*
    begin
        lineTmp = 64'sh0;
        case (scaleMethod) // R7
            `RDP_SM_USER, `RDP_SM_LIVE:
            begin
                lineTmp = $signed({32'h0, calScale1}) + ($signed({32'h0, freqMilli}) / 1000
                    - $signed({32'h0, calFreq1})) * ($signed({32'h0, calScale2}) - $signed({32'h0, calScale1}))
                    / (($signed({32'h0, calFreq2}) == $signed({32'h0, calFreq1})) ? 64'sh1
                    : ($signed({32'h0, calFreq2}) - $signed({32'h0, calFreq1})));
                scaledRate = (lineTmp < 0) ? 32'h0 : lineTmp[31:0];
            end
            default:
                scaledRate = directWide[31:0]; // R8
        endcase
    end

    // ********
    // weighted average filter (1/2^k weighting)
    // ********
    reg [47:0] filterAcc; // value scaled by 2^16
    wire [47:0] target = {scaledRate, 16'h0};
    wire [31:0] filtered = filterAcc[47:16];
    always @(posedge clock)
    begin
        if (!rst_n)
            filterAcc <= 48'h0;
        else if (freqValid)
        begin
            if (filterStrength == 4'h0)
                filterAcc <= target; // R9
            else if (target >= filterAcc)
                filterAcc <= filterAcc + ((target - filterAcc) >> filterStrength); // R9
            else
                filterAcc <= filterAcc - ((filterAcc - target) >> filterStrength); // R9
        end
    end

    // ********
    // averaging: period sum and rolling window of N
    // ********
    reg [31:0] avgPulses; // pulses this period
    reg [15:0] avgSecCnt;
    reg [31:0] history [0:MAXCNT-1]; // period results
    reg [31:0] avgRate; // held averaged rate
    reg [31:0] periodRate;
    reg [47:0] rollSum;
    integer i;
    wire [63:0] periodWide = ({32'h0, avgPulses} * scaleFactor) / inFactor / avgSeconds; // scaled period rate
    wire [47:0] rollMean = rollSum / avgCount; // only used while avgCount is above one
    always @*
    begin
        periodRate = periodWide[31:0]; // R19
        rollSum = {16'h0, periodRate};
        for (i = 0; i < MAXCNT - 1; i = i + 1)
            if (i + 1 < avgCount)
                rollSum = rollSum + {16'h0, history[i]}; // R20
    end
    always @(posedge clock)
    begin
        if (!rst_n || dispOff || !isAvg)
        begin
            avgPulses <= 32'h0;
            avgSecCnt <= 16'h0;
            avgRate <= 32'h0; // R21
            for (i = 0; i < MAXCNT; i = i + 1)
                history[i] <= 32'h0; // R20
        end
        else
        begin
            if (secTick && avgSecCnt + 16'h1 >= avgSeconds)
            begin
                // period end: only moment the averaged value changes
                avgSecCnt <= 16'h0;
                avgPulses <= {31'h0, pulseEdge};
                history[0] <= periodRate;
                for (i = 1; i < MAXCNT; i = i + 1)
                    history[i] <= history[i-1];
                if (rangeSel == `RDP_RNG_ROLL && avgCount > 6'h1)
                    avgRate <= rollMean[31:0]; // R20 R22
                else
                    avgRate <= periodRate; // R19 R22
            end
            else
            begin
                if (secTick)
                    avgSecCnt <= avgSecCnt + 16'h1;
                avgPulses <= avgPulses + {31'h0, pulseEdge};
            end
        end
    end

    // ********
    // rounding and warnings
    // ********
    wire [31:0] rawRate = isAvg ? avgRate : filtered;
    wire [31:0] shownRate = ((rawRate + {16'h0, roundStep >> 1}) / roundStep) * roundStep; // R10
    wire lowWarn = lowEn && (shownRate < lowLimit); // R11 R23
    wire highWarn = highEn && (shownRate > highLimit); // R12 R23

    // ********
    // view selection, revert and identifier timers
    // ********
    reg viewAlt; // non-default view active
    reg [15:0] revertCnt, altIdCnt;
    wire viewTotal = (opMode == `RDP_OP_TOTAL) ? 1'b1 : (opMode == `RDP_OP_RATE) ? 1'b0
        : (defTotal ^ viewAlt); // R1
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            viewAlt <= 1'b0; // R4
            revertCnt <= 16'h0;
            altIdCnt <= 16'h0;
        end
        else if (opMode != `RDP_OP_BOTH)
            viewAlt <= 1'b0; // R1
        else if (btnEdge)
        begin
            viewAlt <= ~viewAlt; // R2
            revertCnt <= 16'h0;
            altIdCnt <= 16'h0;
        end
        else if (viewAlt && tick)
        begin
            revertCnt <= revertCnt + 16'h1;
            altIdCnt <= (altIdCnt == ALTID_T - 16'h1) ? 16'h0 : altIdCnt + 16'h1; // R5
            if (revertCnt == REVERT_T - 16'h1)
                viewAlt <= 1'b0; // R3
        end
    end

    // ********
    // display output
    // ********
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            {dispValue, dispPoint, dispMessage, showingTotal} <= 39'h0; // value message is code zero
        end
        else
        begin
            showingTotal <= viewTotal;
            dispValue <= viewTotal ? totalValue : shownRate;
            dispPoint <= viewTotal ? 3'h0 : ratePoint; // R6
            if (viewAlt && altIdCnt >= ALTID_T - `RDP_ALTID_SHOW_TICKS)
                dispMessage <= `RDP_MSG_ALTID; // R5
            else if (viewTotal || !(lowWarn || highWarn) || !blinkOn)
                dispMessage <= (!viewTotal && (lowWarn || highWarn) && warnStyle == `RDP_WS_FLASH)
                    ? `RDP_MSG_BLANK : `RDP_MSG_VALUE; // R13 R16
            else
            begin
                case (warnStyle)
                    `RDP_WS_DASH: dispMessage <= `RDP_MSG_DASH; // R14
                    `RDP_WS_OFUF: dispMessage <= highWarn ? `RDP_MSG_OVER : `RDP_MSG_UNDER; // R15
                    `RDP_WS_HILO: dispMessage <= highWarn ? `RDP_MSG_HIGH : `RDP_MSG_LOW; // R15
                    default: dispMessage <= `RDP_MSG_VALUE;
                endcase
            end
        end
    end

    // ********
    // register read port, data one cycle later
    // ********
    always @(posedge clock)
    begin
        if (!rst_n)
            regRdData <= 32'h0;
        else if (regRead)
        begin
            case (regAddr)
                `RDP_ADDR_MODE: regRdData <= {16'h0, modeReg};
                `RDP_ADDR_INFACT: regRdData <= inFactor;
                `RDP_ADDR_SCALE: regRdData <= scaleFactor;
                `RDP_ADDR_FILT: regRdData <= {28'h0, filterStrength};
                `RDP_ADDR_ROUND: regRdData <= {16'h0, roundStep};
                `RDP_ADDR_LOLIM: regRdData <= lowLimit;
                `RDP_ADDR_HILIM: regRdData <= highLimit;
                `RDP_ADDR_AVG: regRdData <= {10'h0, avgCount, avgSeconds};
                `RDP_ADDR_TIMEOUT: regRdData <= {16'h0, timeoutSec};
                `RDP_ADDR_CAL: regRdData <= {30'h0, calSel};
                `RDP_ADDR_STATUS: regRdData <= {28'h0, highWarn, lowWarn, viewAlt, viewTotal};
                `RDP_ADDR_RATE: regRdData <= shownRate;
                default: regRdData <= 32'h0;
            endcase
        end
        else
            regRdData <= 32'h0;
    end
endmodule
`default_nettype wire

/* File: hw/rdp_display_regs.vh */
`ifndef RDP_DISPLAY_REGS_VH
`define RDP_DISPLAY_REGS_VH
// ********
// register offsets (word addresses)
// ********
`define RDP_ADDR_MODE 4'h0
`define RDP_ADDR_INFACT 4'h1
`define RDP_ADDR_SCALE 4'h2
`define RDP_ADDR_FILT 4'h3
`define RDP_ADDR_ROUND 4'h4
`define RDP_ADDR_LOLIM 4'h5
`define RDP_ADDR_HILIM 4'h6
`define RDP_ADDR_AVG 4'h7
`define RDP_ADDR_TIMEOUT 4'h8
`define RDP_ADDR_CAL 4'h9
`define RDP_ADDR_STATUS 4'hA
`define RDP_ADDR_RATE 4'hB
// ********
// mode register field positions
// ********
`define RDP_MODE_OP_LSB 0
`define RDP_MODE_DEF_BIT 2
`define RDP_MODE_DP_LSB 3
`define RDP_MODE_SM_LSB 6
`define RDP_MODE_WS_LSB 8
`define RDP_MODE_RNG_LSB 11
`define RDP_MODE_LOEN_BIT 13
`define RDP_MODE_HIEN_BIT 14
`define RDP_MODE_DISPOFF_BIT 15
// ********
// encodings
// ********
`define RDP_OP_RATE 2'h0
`define RDP_OP_TOTAL 2'h1
`define RDP_OP_BOTH 2'h2
`define RDP_SM_INPUT 2'h0
`define RDP_SM_USER 2'h1
`define RDP_SM_LIVE 2'h2
`define RDP_WS_NONE 3'h0
`define RDP_WS_FLASH 3'h1
`define RDP_WS_DASH 3'h2
`define RDP_WS_OFUF 3'h3
`define RDP_WS_HILO 3'h4
`define RDP_RNG_LOF 2'h0
`define RDP_RNG_HIF 2'h1
`define RDP_RNG_AVG 2'h2
`define RDP_RNG_ROLL 2'h3
`define RDP_MSG_VALUE 3'h0
`define RDP_MSG_BLANK 3'h1
`define RDP_MSG_DASH 3'h2
`define RDP_MSG_OVER 3'h3
`define RDP_MSG_UNDER 3'h4
`define RDP_MSG_HIGH 3'h5
`define RDP_MSG_LOW 3'h6
`define RDP_MSG_ALTID 3'h7
// ********
// reset values and timing
// ********
`define RDP_RST_MODE 16'h0800
`define RDP_RST_FACTOR 32'h00000001
`define RDP_RST_ROUND 16'h0001
`define RDP_RST_AVGSEC 16'h0004
`define RDP_RST_AVGCNT 6'h04
`define RDP_RST_TIMEOUT 16'h0028
`define RDP_CLOCK_HZ 40000000
`define RDP_REVERT_S 30
`define RDP_ALTID_S 8
`define RDP_ALTID_SHOW_TICKS 10
`define RDP_HIF_GATE_TICKS 2
`endif

/* File: bench/rdp_display_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// display port checker
// ********
module rdp_display_properties #(
    parameter DIGITS = 6
)(
    input wire clock,
    input wire rst_n,
    input wire toggleBtn,
    input wire regWrite,
    input wire [3:0] regAddr,
    input wire [31:0] regWrData,
    input wire [31:0] totalValue,
    input wire [31:0] dispValue,
    input wire [2:0] dispPoint,
    input wire [2:0] dispMessage,
    input wire showingTotal
);
    reg [15:0] modeR; // shadow of the mode word
    reg [15:0] stepR; // shadow of the rounding step
    reg [7:0] quiet; // cycles since the last write, saturating
    reg [11:0] away; // cycles spent in the alternate view
    // shadows follow the bus, so settings are known without peeking inside
    always @(posedge clock)
    begin
        if (!rst_n)
            modeR <= 16'h0800;
        else if (regWrite && regAddr == 4'h0)
            modeR <= regWrData[15:0];
        stepR <= !rst_n ? 16'h0001 : (regWrite && regAddr == 4'h4) ? regWrData[15:0] : stepR;
        quiet <= (!rst_n || regWrite) ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};
        away <= (!rst_n || regWrite || modeR[1:0] != 2'h2 || showingTotal == modeR[2]) ? 12'h000 : away + 12'h001;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    a_reset_clear: assert property ($rose(rst_n) |-> dispValue == 32'h0 && !showingTotal)
        else $error("outputs not clear after reset");
    a_rate_only: assert property (quiet > 8'h04 && modeR[1:0] == 2'h0 |-> !showingTotal)
        else $error("total shown in rate only mode");
    a_total_only: assert property (quiet > 8'h04 && modeR[1:0] == 2'h1 |-> showingTotal)
        else $error("rate shown in total only mode");
    a_total_value: assert property (showingTotal && $past(showingTotal) |-> dispValue == $past(totalValue))
        else $error("total view not showing total");
    a_point_range: assert property (dispPoint <= DIGITS - 1)
        else $error("point beyond digit count");
    a_button_toggle: assert property ($rose(toggleBtn) && modeR[1:0] == 2'h2 |-> ##[1:6] $changed(showingTotal))
        else $error("button did not toggle view");
    a_step_multiple: assert property (quiet == 8'hFF && !showingTotal && dispMessage == 3'h0 |-> dispValue % stepR == 0)
        else $error("rate not a multiple of step");
    a_none_quiet: assert property (quiet > 8'h04 && !modeR[15] && modeR[10:8] == 3'h0 |-> dispMessage inside {3'h0, 3'h7})
        else $error("warning shown with warnings off");
    a_dash_style: assert property (quiet > 8'h04 && modeR[10:8] == 3'h2 |-> dispMessage inside {3'h0, 3'h2, 3'h7})
        else $error("wrong message in dash style");
    a_alt_view: assert property (quiet > 8'h04 && dispMessage == 3'h7 |-> showingTotal != modeR[2])
        else $error("view id shown in default view");
    a_view_revert: assert property (away < 12'd3040)
        else $error("alternate view held too long");
endmodule
bind rdp_display_core rdp_display_properties #(.DIGITS(DIGITS)) rdp_display_properties_i (.*);
`default_nettype wire

/* File: bench/rdp_pulse_source.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// pulse source and front button
// ********
module rdp_pulse_source (
    input wire logic clock,
    input wire logic [7:0] period, // clocks per pulse, 0 keeps the line low
    input wire logic press, // one-cycle request for a button press
    output logic pulseIn,
    output logic toggleBtn
);
    logic [7:0] phase = 8'h00; // place within the pulse period
    logic [2:0] held = 3'h0; // cycles the contact stays closed
    initial {pulseIn, toggleBtn} = 2'b00;
    // contact held several clocks so the two-stage sync cannot miss it
    always @(posedge clock)
    begin
        phase <= (period == 8'h00 || phase + 8'h01 >= period) ? 8'h00 : phase + 8'h01;
        pulseIn <= period != 8'h00 && phase < period >> 1;
        held <= press ? 3'h4 : held - {2'h0, held != 3'h0};
        toggleBtn <= held != 3'h0;
    end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] period = 8'h00; // pulse spacing for the source
    logic press = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] totalValue = 32'h1234;
    wire [31:0] regRdData, dispValue;
    wire [2:0] dispPoint, dispMessage;
    wire showingTotal, pulseIn, toggleBtn;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    // one second is 100 clocks, so revert and flash timing stay short
    rdp_display_core #(.CLK_PER_SEC(100)) rdp_display_core_i (.*);
    rdp_pulse_source rdp_pulse_source_i (.*);
    initial forever #12.5 clock = ~clock;
    task print_verdict;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // hang guard: the whole run needs well under this many clocks
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 15000)
        begin
            err_count++;
            print_verdict;
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] expv, input string what);
        n_tests++;
        if (seen !== expv)
        begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, expv, seen);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask
    task tap;
        @(posedge clock);
        press <= 1'b1;
        @(posedge clock);
        press <= 1'b0;
    endtask
    task t_reset;
        logic [31:0] d;
        check(dispValue, 32'h0, "value");
        check(showingTotal, 32'h0, "view");
        rd(4'h0, d);
        check(d, 32'h0800, "mode");
        rd(4'hC, d);
        check(d, 32'h0, "unmapped");
    endtask
    // 25 Hz input, scale 2 over input 1, shows 50
    task t_rate;
        logic [31:0] d;
        period <= 8'h04;
        wr(4'h3, 32'h0);
        wr(4'h2, 32'h2);
        cyc(200);
        rd(4'hB, d);
        check(d, 32'd50, "rate");
        wr(4'h4, 32'd30);
        cyc(300);
        check(dispValue, 32'd60, "rounded");
        wr(4'h4, 32'h1);
    endtask
    task t_slow;
        wr(4'h8, 32'h3);
        wr(4'h0, 32'h0);
        cyc(300);
        check(dispValue, 32'd50, "slow rate");
        period <= 8'h00;
        cyc(150);
        check(dispValue, 32'd50, "held");
        cyc(200);
        check(dispValue, 32'h0, "timed out");
        period <= 8'h04;
        wr(4'h0, 32'h0800);
        cyc(100);
    endtask
    // expected message must appear, and nothing but it and the value
    task t_warn(input logic [15:0] m, input logic [31:0] lo, input logic [31:0] hi, input logic [2:0] e);
        logic hit, odd;
        wr(4'h5, lo);
        wr(4'h6, hi);
        wr(4'h0, {16'h0, m});
        cyc(5);
        {hit, odd} = 2'b00;
        repeat (250)
        begin
            cyc(1);
            hit |= dispMessage === e;
            odd |= dispMessage !== e && dispMessage !== 3'h0;
        end
        check({hit, odd}, 32'h2, "message");
    endtask
    task t_view;
        logic alt;
        wr(4'h0, 32'h0802);
        tap;
        cyc(10);
        check(showingTotal, 32'h1, "toggle");
        check(dispValue, totalValue, "total");
        alt = 1'b0;
        repeat (900)
        begin
            cyc(1);
            alt |= dispMessage === 3'h7;
        end
        check(alt, 32'h1, "view id");
        cyc(1900);
        check(showingTotal, 32'h1, "still total");
        cyc(300);
        check(showingTotal, 32'h0, "reverted");
        wr(4'h0, 32'h0800);
        tap;
        cyc(10);
        check(showingTotal, 32'h0, "rate only");
        wr(4'h0, 32'h0801);
        cyc(10);
        check(showingTotal, 32'h1, "total only");
    endtask
    task t_point;
        wr(4'h0, 32'h0838);
        cyc(5);
        check(dispPoint, 32'h5, "point clamp");
        wr(4'h0, 32'h0818);
        cyc(5);
        check(dispPoint, 32'h3, "point");
    endtask
    task t_avg;
        logic [31:0] d;
        wr(4'h7, 32'h00020001);
        wr(4'h0, 32'h1000);
        cyc(300);
        check(dispValue, 32'd50, "average");
        wr(4'h0, 32'h1800);
        cyc(500);
        check(dispValue, 32'd50, "rolling");
        wr(4'h0, 32'h9800);
        cyc(5);
        rd(4'hB, d);
        check(d, 32'h0, "display off");
    endtask
    initial
    begin
        cyc(6);
        rst_n <= 1'b1;
        cyc(2);
        t_reset;
        t_rate;
        t_slow;
        t_warn(16'h4900, 32'd0, 32'd40, 3'h1);
        t_warn(16'h4A00, 32'd0, 32'd40, 3'h2);
        t_warn(16'h4B00, 32'd0, 32'd40, 3'h3);
        t_warn(16'h2B00, 32'd100, 32'd0, 3'h4);
        t_warn(16'h4C00, 32'd0, 32'd40, 3'h5);
        t_warn(16'h2C00, 32'd100, 32'd0, 3'h6);
        t_warn(16'h6C00, 32'd10, 32'd100, 3'h0);
        t_warn(16'h2800, 32'd100, 32'd0, 3'h0);
        t_view;
        t_point;
        t_avg;
        print_verdict;
    end
endmodule
`default_nettype wire
